// [rtl/core_ctrl_pkg.sv]
// Constants shared by the core control register block.
// Assumes a byte-wide register port driven by the core's data memory decoder.
package core_ctrl_pkg;
    // Register offsets in data memory.
    localparam logic [7:0] ADDR_INTERRUPT_CONTROL  = 8'h0b;
    localparam logic [7:0] ADDR_PERIPH_IRQ_FLAGS   = 8'h0c;
    localparam logic [7:0] ADDR_TIMER_PRESCALE_OPT = 8'h81;
    localparam logic [7:0] ADDR_PERIPH_IRQ_ENABLES = 8'h8c;
    localparam logic [7:0] ADDR_POWER_RESET_STATUS = 8'h8e;
    localparam logic [7:0] ADDR_OSCILLATOR_TRIM    = 8'h8f;
    localparam logic [7:0] ADDR_PC_LOW_BYTE        = 8'h02;
    localparam logic [7:0] ADDR_PC_HIGH_LATCH      = 8'h0a;
    // Options register fields.
    localparam int OPT_PULLUP_BIT    = 7;
    localparam int OPT_EDGE_BIT      = 6;
    localparam int OPT_TCS_BIT       = 5;
    localparam int OPT_TSE_BIT       = 4;
    localparam int OPT_ASSIGN_BIT    = 3;
    // Interrupt control fields.
    localparam int IC_GIE_BIT  = 7;
    localparam int IC_PERIPH_IRQ_ENABLE_BIT = 6;
    localparam int IC_TIE_BIT  = 5;
    localparam int IC_EIE_BIT  = 4;
    localparam int IC_PIE_BIT  = 3;
    localparam int IC_TIF_BIT  = 2;
    localparam int IC_EIF_BIT  = 1;
    localparam int IC_PIF_BIT  = 0;
    // Peripheral, power and trim fields.
    localparam int CONV_DONE_BIT   = 6;
    localparam int POR_STATUS_BIT  = 1;
    localparam int TRIM_FASTER_BIT = 3;
    localparam int TRIM_SLOWER_BIT = 2;
    // Reset values.
    localparam logic [7:0] RST_OPTIONS   = 8'hff;
    localparam logic [7:0] RST_INTCTL    = 8'h00;
    localparam logic [7:0] RST_TRIM      = 8'h70;
    localparam logic [7:0] MASK_TRIM     = 8'hfc;
    // Program counter geometry.
    localparam int PC_WIDTH    = 13;
    localparam int STACK_DEPTH = 8;
    // Stack operations requested by the instruction sequencer.
    typedef enum logic [1:0] {STK_NONE, STK_PUSH, STK_POP} stack_op_type;
endpackage

// [rtl/core_control_regs_pc_stack.sv]
// Core control registers, program counter and return stack.
// Assumes the sequencer gives one-cycle strobes and a single instruction clock.
// Assumes the data memory decoder never raises write and read strobes together.
// Assumes event inputs (timer overflow, conversion done) are one-cycle pulses.
// Assumes pin inputs are already synchronous to the instruction clock.
// The timer, watchdog, converter and oscillator themselves live elsewhere;
// this block only holds their controls and collects their events.
module core_control_regs_pc_stack
    import core_ctrl_pkg::*;
#(
    parameter int DEPTH = STACK_DEPTH
) (
    input  wire logic                i_clk,
    input  wire logic                i_rstn,
    input  wire logic                i_por_pulse,
    input  wire logic [7:0]          i_addr,
    input  wire logic [7:0]          i_wdata,
    input  wire logic                i_wr,
    input  wire logic                i_rd,
    output logic      [7:0]          o_rdata,
    input  wire logic                i_pc_inc,
    input  wire logic                i_jump,
    input  wire logic [10:0]         i_jump_target,
    input  wire logic                i_vector,
    input  wire logic [PC_WIDTH-1:0] i_vector_addr,
    input  wire stack_op_type        i_stack_op,
    output logic      [PC_WIDTH-1:0] o_pc,
    input  wire logic                i_timer_overflow,
    input  wire logic                i_ext_pin,
    input  wire logic [2:0]          i_port_pins,
    input  wire logic                i_conv_done,
    output logic                     o_irq,
    output logic                     o_pullup_en,
    output logic                     o_ext_irq_edge_sel,
    output logic                     o_timer_clock_source_sel,
    output logic                     o_timer_source_edge_sel,
    output logic                     o_prescaler_assign,
    output logic      [8:0]          o_timer_divide,
    output logic      [7:0]          o_watchdog_divide,
    output logic      [3:0]          o_trim_fine,
    output logic      [1:0]          o_trim_step
);

    ////////////////////////////////////////////////////////////////////////////
    // Register storage.
    logic [7:0]          options_reg;     // Prescale and edge options.
    logic [7:0]          intctl_reg;      // Enables and core flags.
    logic                conv_flag_reg;   // Converter done flag.
    logic                conv_en_reg;     // Converter done enable.
    logic                por_status_reg;  // Power-on reset status.
    logic [7:0]          trim_reg;        // Oscillator trim.
    logic [4:0]          pc_latch_reg;    // Upper counter holding latch.
    logic [PC_WIDTH-1:0] pc_reg;          // Program counter.
    logic [PC_WIDTH-1:0] stack_reg [DEPTH];
    logic [$clog2(DEPTH)-1:0] sp_reg;     // Hidden stack pointer.
    logic                ext_pin_reg;     // Previous pin level.
    logic [2:0]          port_prev_reg;   // Previous port levels.
    logic                init_reg;        // History registers hold valid data.

    // Write decode helpers.
    // Two flag registers need a decoded write because a hardware set must be
    // merged into the same update rather than losing the race to software.
    logic wr_ic;
    logic wr_pf;
    assign wr_ic = i_wr && (i_addr == ADDR_INTERRUPT_CONTROL);
    assign wr_pf = i_wr && (i_addr == ADDR_PERIPH_IRQ_FLAGS);

    ////////////////////////////////////////////////////////////////////////////
    // Options register and the controls it drives.
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            options_reg <= RST_OPTIONS;
        end else if (i_wr && i_addr == ADDR_TIMER_PRESCALE_OPT) begin
            options_reg <= i_wdata;
        end
    end

    assign o_pullup_en              = ~options_reg[OPT_PULLUP_BIT];
    assign o_ext_irq_edge_sel       = options_reg[OPT_EDGE_BIT];
    assign o_timer_clock_source_sel = options_reg[OPT_TCS_BIT];
    assign o_timer_source_edge_sel  = options_reg[OPT_TSE_BIT];
    assign o_prescaler_assign       = options_reg[OPT_ASSIGN_BIT];
    // divide ratios; the unassigned user sees 1:1.
    assign o_timer_divide    = options_reg[OPT_ASSIGN_BIT] ? 9'h001 : (9'h002 << options_reg[2:0]);
    assign o_watchdog_divide = options_reg[OPT_ASSIGN_BIT] ? (8'h01 << options_reg[2:0]) : 8'h01;

    ////////////////////////////////////////////////////////////////////////////
    // Event detection: edges on the pins, compared with last cycle's levels.
    logic ext_edge;
    logic port_change;
    assign ext_edge    = init_reg && (options_reg[OPT_EDGE_BIT] ? (i_ext_pin && !ext_pin_reg)
                                                                : (!i_ext_pin && ext_pin_reg));
    assign port_change = init_reg && (i_port_pins != port_prev_reg);

    // Histories start invalid so the first sample after reset raises nothing.
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ext_pin_reg   <= 1'b0;
            port_prev_reg <= 3'h0;
            init_reg      <= 1'b0;
        end else begin
            ext_pin_reg   <= i_ext_pin;
            port_prev_reg <= i_port_pins;
            init_reg      <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt control: a hardware set wins over a software clear.
    logic [2:0] core_set;
    assign core_set = {i_timer_overflow, ext_edge, port_change};

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            intctl_reg <= RST_INTCTL;
        end else begin
            if (wr_ic) begin
                intctl_reg <= i_wdata | {5'h00, core_set};
            end else begin
                intctl_reg[2:0] <= intctl_reg[2:0] | core_set;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            conv_flag_reg <= 1'b0;
            conv_en_reg   <= 1'b0;
        end else begin
            conv_flag_reg <= (wr_pf ? i_wdata[CONV_DONE_BIT] : conv_flag_reg) | i_conv_done;
            if (i_wr && i_addr == ADDR_PERIPH_IRQ_ENABLES) begin
                conv_en_reg <= i_wdata[CONV_DONE_BIT];
            end
        end
    end

    // Interrupt request to the core; is left to software.
    logic core_req;
    logic periph_req;
    assign core_req   = |(intctl_reg[5:3] & intctl_reg[2:0]);
    assign periph_req = intctl_reg[IC_PERIPH_IRQ_ENABLE_BIT] && conv_en_reg && conv_flag_reg;
    assign o_irq      = intctl_reg[IC_GIE_BIT] && (core_req || periph_req);

    ////////////////////////////////////////////////////////////////////////////
    // Power status: the power-on pulse or a software write of zero clears it; other resets keep it.
    // power-on clears status
    always_ff @(posedge i_clk) begin
        if (i_por_pulse) begin
            por_status_reg <= 1'b0;
        end else if (i_wr && i_addr == ADDR_POWER_RESET_STATUS) begin
            por_status_reg <= i_wdata[POR_STATUS_BIT];
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            trim_reg <= RST_TRIM;
        end else if (i_wr && i_addr == ADDR_OSCILLATOR_TRIM) begin
            trim_reg <= i_wdata & MASK_TRIM;
        end
    end

    // faster has precedence; step is +1 (01), -1 (10) or none.
    assign o_trim_fine = trim_reg[7:4];
    assign o_trim_step = trim_reg[TRIM_FASTER_BIT] ? 2'h1 :
                         (trim_reg[TRIM_SLOWER_BIT] ? 2'h2 : 2'h0);

    ////////////////////////////////////////////////////////////////////////////
    // Program counter and latch.
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pc_latch_reg <= 5'h00;
        end else if (i_wr && i_addr == ADDR_PC_HIGH_LATCH) begin
            pc_latch_reg <= i_wdata[4:0];
        end
    end

    // Page bits used by jumps, kept apart so the checks can look back at them.
    logic [1:0] jump_page;
    assign jump_page = pc_latch_reg[4:3];

    // Priority: reset, vector, return, low-byte write, jump, increment.
    // The sequencer should never ask for two of these in one cycle; if it does,
    // the order below decides and the lower requests are simply dropped.
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pc_reg <= '0;
        end else if (i_vector) begin
            pc_reg <= i_vector_addr;
        end else if (i_stack_op == STK_POP) begin
            pc_reg <= stack_reg[sp_reg - 1'b1];
        end else if (i_wr && i_addr == ADDR_PC_LOW_BYTE) begin
            pc_reg <= {pc_latch_reg, i_wdata};
        end else if (i_jump) begin
            pc_reg <= {pc_latch_reg[4:3], i_jump_target};
        end else if (i_pc_inc) begin
            pc_reg <= pc_reg + 1'b1;
        end
    end
    assign o_pc = pc_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Return stack; the pointer wraps naturally at its width.
    // DEPTH must be a power of two, otherwise the wrap would skip entries.
    // A pop on an empty stack returns whatever the ring held; nothing reports it.
    // push on call or vector
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sp_reg <= '0;
        end else if (i_stack_op == STK_PUSH) begin
            sp_reg <= sp_reg + 1'b1;
        end else if (i_stack_op == STK_POP) begin
            sp_reg <= sp_reg - 1'b1;
        end
    end

    // The pushed value is the return address supplied by the counter now.
    genvar g;
    generate
        for (g = 0; g < DEPTH; g++) begin : g_stack
            always_ff @(posedge i_clk) begin
                if (i_stack_op == STK_PUSH && sp_reg == g) begin
                    stack_reg[g] <= pc_reg;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Read port: data stand one cycle after the strobe; unmapped reads zero.
    // unimplemented bits zero
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            unique case (i_addr)
                ADDR_INTERRUPT_CONTROL:  o_rdata <= intctl_reg;
                ADDR_PERIPH_IRQ_FLAGS:   o_rdata <= {1'b0, conv_flag_reg, 6'h00};
                ADDR_TIMER_PRESCALE_OPT: o_rdata <= options_reg;
                ADDR_PERIPH_IRQ_ENABLES: o_rdata <= {1'b0, conv_en_reg, 6'h00};
                ADDR_POWER_RESET_STATUS: o_rdata <= {6'h00, por_status_reg, 1'b0};
                ADDR_OSCILLATOR_TRIM:    o_rdata <= trim_reg;
                ADDR_PC_LOW_BYTE:        o_rdata <= pc_reg[7:0];
                ADDR_PC_HIGH_LATCH:      o_rdata <= {3'h0, pc_latch_reg};
                default:                 o_rdata <= 8'h00;
            endcase
        end else begin
            o_rdata <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    // Each check watches state or outputs that this block drives itself.

    // External edge must land in its flag, even beside a software write.
    a_ext_flag_set: assert property (@(posedge i_clk) disable iff (!i_rstn)
        ext_edge |=> intctl_reg[IC_EIF_BIT])
        else $error("edge flag not set");

    // Any change on the watched port pins must land in its flag.
    a_port_flag_set: assert property (@(posedge i_clk) disable iff (!i_rstn)
        port_change |=> intctl_reg[IC_PIF_BIT])
        else $error("change flag not set");

    // A set timer flag stays set until software writes the register.
    a_timer_flag_hold: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (intctl_reg[IC_TIF_BIT] && !wr_ic) |=> intctl_reg[IC_TIF_BIT])
        else $error("timer flag lost");

    // A set conversion flag stays set until software writes the register.
    a_conv_flag_hold: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (conv_flag_reg && !wr_pf) |=> conv_flag_reg)
        else $error("conv flag lost");

    // The power-on marker clears the status bit at the next edge.
    a_por_clear: assert property (@(posedge i_clk) disable iff (!i_rstn)
        i_por_pulse |=> !por_status_reg)
        else $error("status not cleared");

    // Only one user of the prescaler may see a division other than 1:1.
    a_one_owner: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (o_timer_divide == 9'h001) || (o_watchdog_divide == 8'h01))
        else $error("prescaler shared");

    // A jump takes only the two page bits of the latch.
    a_pc_jump: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_jump && !i_vector && i_stack_op != STK_POP && !(i_wr && i_addr == ADDR_PC_LOW_BYTE))
        |=> o_pc == {$past(jump_page), $past(i_jump_target)})
        else $error("jump target wrong");

    // A plain step adds one to the counter.
    a_pc_step: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_pc_inc && !i_jump && !i_vector && i_stack_op != STK_POP && !(i_wr && i_addr == ADDR_PC_LOW_BYTE))
        |=> o_pc == $past(pc_reg) + 13'h0001)
        else $error("pc step wrong");

    // Push and pop leave the high latch alone.
    a_latch_untouched: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_stack_op != STK_NONE && !(i_wr && i_addr == ADDR_PC_HIGH_LATCH)) |=> $stable(pc_latch_reg))
        else $error("latch moved by stack");

    // Read data is zero whenever no read was taken on the previous edge.
    a_rdata_idle: assert property (@(posedge i_clk) disable iff (!i_rstn)
        !i_rd |=> o_rdata == 8'h00)
        else $error("read data not idle");

    // Unimplemented status bits always read as zero.
    a_status_unimpl: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_rd && i_addr == ADDR_POWER_RESET_STATUS) |=> (o_rdata[7:2] == 6'h00 && !o_rdata[0]))
        else $error("status spare bits set");

    a_flag_set_wins: assert property (@(posedge i_clk) disable iff (!i_rstn)
        i_timer_overflow |=> intctl_reg[IC_TIF_BIT])
        else $error("timer flag not set");
    a_conv_flag_set: assert property (@(posedge i_clk) disable iff (!i_rstn)
        i_conv_done |=> conv_flag_reg)
        else $error("conv flag not set");
    a_global_gate: assert property (@(posedge i_clk) disable iff (!i_rstn)
        !intctl_reg[IC_GIE_BIT] |-> !o_irq)
        else $error("irq while global off");
    a_periph_gate: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (o_irq && !core_req) |-> intctl_reg[IC_PERIPH_IRQ_ENABLE_BIT])
        else $error("periph irq ungated");
    a_pc_low_write: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_wr && i_addr == ADDR_PC_LOW_BYTE && !i_vector && i_stack_op != STK_POP)
        |=> o_pc == {$past(pc_latch_reg), $past(i_wdata)})
        else $error("pc load wrong");
    a_stack_return: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_stack_op == STK_PUSH && !i_vector) ##1 (i_stack_op == STK_POP && !i_vector)
        |=> o_pc == $past(pc_reg, 2))
        else $error("return address wrong");
    a_pullup_polar: assert property (@(posedge i_clk) disable iff (!i_rstn)
        o_pullup_en != options_reg[OPT_PULLUP_BIT])
        else $error("pullup polarity");
    a_trim_prio: assert property (@(posedge i_clk) disable iff (!i_rstn)
        trim_reg[TRIM_FASTER_BIT] |-> o_trim_step == 2'h1)
        else $error("trim priority");
    a_pc_reset: assert property (@(posedge i_clk)
        $rose(i_rstn) |-> o_pc == '0)
        else $error("pc not cleared");
endmodule

// [test/core_control_regs_pc_stack_tb.sv]
// Self-checking bench for the core control register block.
// Assumes the control package is compiled first; one 100 MHz clock.
module core_control_regs_pc_stack_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import core_ctrl_pkg::*;
    ////////////////////////////////////////////////////////////
    logic         clk    = 1'b0;   // Instruction clock.
    logic         rst_n  = 1'b0;   // Reset, held low at start.
    logic         por    = 1'b0;   // Power-on marker.
    logic [7:0]   addr   = 8'h00;  // Register address.
    logic [7:0]   wdata  = 8'h00;  // Register write data.
    logic         wr     = 1'b0;   // Write strobe.
    logic         rd     = 1'b0;   // Read strobe.
    logic [7:0]   rdata;           // Read data.
    logic         pc_inc = 1'b0;   // Counter step.
    logic         jump   = 1'b0;   // Jump strobe.
    logic [10:0]  jtgt   = 11'h000;
    logic         vec    = 1'b0;   // Vector strobe.
    logic [12:0]  vaddr  = 13'h0004;
    stack_op_type sop    = STK_NONE;
    logic [12:0]  pc;
    logic         tovf   = 1'b0;   // Timer overflow event.
    logic         ext    = 1'b0;   // External interrupt pin.
    logic [2:0]   pins   = 3'h0;   // Change-watched port pins.
    logic         conv   = 1'b0;   // Conversion done event.
    logic         irq, pu, es, tcs, tse, prescaler_assign;
    logic [8:0]   tdiv;
    logic [7:0]   wdiv;
    logic [3:0]   tfine;
    logic [1:0]   tstep;
    logic [7:0]   exp_q[$];        // Expected read data, oldest first.
    logic         rd_seen = 1'b0;  // A read was taken last edge.
    logic [31:0]  seed = 32'd68;   // Random state.
    int           bad_count = 0;
    int           checked = 0;

    always #5 clk = ~clk;

    core_control_regs_pc_stack #(.DEPTH(8)) i_core_control_regs_pc_stack (
        .i_clk(clk), .i_rstn(rst_n), .i_por_pulse(por), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_pc_inc(pc_inc), .i_jump(jump),
        .i_jump_target(jtgt), .i_vector(vec), .i_vector_addr(vaddr), .i_stack_op(sop),
        .o_pc(pc), .i_timer_overflow(tovf), .i_ext_pin(ext), .i_port_pins(pins),
        .i_conv_done(conv), .o_irq(irq), .o_pullup_en(pu), .o_ext_irq_edge_sel(es),
        .o_timer_clock_source_sel(tcs), .o_timer_source_edge_sel(tse),
        .o_prescaler_assign(prescaler_assign), .o_timer_divide(tdiv), .o_watchdog_divide(wdiv),
        .o_trim_fine(tfine), .o_trim_step(tstep));
    ////////////////////////////////////////////////////////////
    // Watcher: read data stands only in the cycle after the strobe, so it is
    // taken at the next edge and matched with the oldest queued note.
    always @(posedge clk) begin
        if (rd_seen) begin
            checked++;
            if (exp_q.size() == 0 || rdata !== exp_q[0]) begin
                bad_count++;
                $display("ERROR at %0t: read data %h unexpected", $time, rdata);
            end
            if (exp_q.size() != 0) void'(exp_q.pop_front());
        end
        rd_seen = rd;
    end

    // Compares a settled output against its expected value.
    task automatic check_out(input logic [12:0] got, input logic [12:0] want);
        checked++;
        if (got !== want) begin
            bad_count++;
            $display("ERROR at %0t: output %h expected %h", $time, got, want);
        end
    endtask

    // One register cycle; strobes drop at the next edge, leaving a gap.
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= w;
        rd <= ~w;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
    endtask

    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
        @(negedge clk);
    endtask

    task automatic rreg(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 8'h00);
    endtask

    // One-cycle pulse on an event or sequencer input, picked by code.
    task automatic pulse(input int k);
        @(posedge clk);
        case (k)
            0: tovf <= 1'b1;
            1: conv <= 1'b1;
            2: pc_inc <= 1'b1;
            3: jump <= 1'b1;
            4: vec <= 1'b1;
            default: por <= 1'b1;
        endcase
        @(posedge clk);
        {tovf, conv, pc_inc, jump, vec, por} <= 6'h00;
        @(negedge clk);
    endtask

    task automatic stk(input stack_op_type op);
        @(posedge clk);
        sop <= op;
        @(posedge clk);
        sop <= STK_NONE;
        @(negedge clk);
    endtask

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    task automatic give_verdict;
        if (exp_q.size() != 0) bad_count++;
        $display("Comparisons %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    // A hang is cut short here and counted as a mismatch.
    initial begin
        repeat (100000) @(posedge clk);
        bad_count++;
        $display("ERROR at %0t: run limit reached", $time);
        give_verdict();
    end

    initial begin
        logic [7:0] v;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        pulse(5);
        rreg(ADDR_POWER_RESET_STATUS, 8'h00);
        rreg(ADDR_TIMER_PRESCALE_OPT, RST_OPTIONS);
        rreg(ADDR_OSCILLATOR_TRIM, RST_TRIM);
        rreg(8'h40, 8'h00);
        check_out(pc, 13'h0000);
        // Every rate for both prescaler owners, random upper option bits.
        for (int n = 0; n < 16; n++) begin
            seed = xs(seed);
            v = {seed[7:4], n[3:0]};
            wreg(ADDR_TIMER_PRESCALE_OPT, v);
            check_out({8'h00, pu, es, tcs, tse, prescaler_assign}, {8'h00, ~v[7], v[6:3]});
            check_out(13'(tdiv), v[3] ? 13'h1 : 13'h2 << v[2:0]);
            check_out(13'(wdiv), v[3] ? 13'h1 << v[2:0] : 13'h1);
            rreg(ADDR_TIMER_PRESCALE_OPT, v);
        end
        // Timer flag sets with all enables off; only software clears it.
        wreg(ADDR_TIMER_PRESCALE_OPT, 8'hff);
        pulse(0);
        rreg(ADDR_INTERRUPT_CONTROL, 8'h04);
        check_out(13'(irq), 13'h0);
        wreg(ADDR_INTERRUPT_CONTROL, 8'h24);
        check_out(13'(irq), 13'h0);
        wreg(ADDR_INTERRUPT_CONTROL, 8'ha4);
        check_out(13'(irq), 13'h1);
        wreg(ADDR_INTERRUPT_CONTROL, 8'h00);
        rreg(ADDR_INTERRUPT_CONTROL, 8'h00);
        // Pin edges: rising selected, then falling; wrong edge is ignored.
        ext <= 1'b1;
        rreg(ADDR_INTERRUPT_CONTROL, 8'h02);
        wreg(ADDR_INTERRUPT_CONTROL, 8'h00);
        wreg(ADDR_TIMER_PRESCALE_OPT, 8'hbf);
        @(posedge clk);
        ext <= 1'b0;
        rreg(ADDR_INTERRUPT_CONTROL, 8'h02);
        wreg(ADDR_INTERRUPT_CONTROL, 8'h00);
        @(posedge clk);
        ext <= 1'b1;
        rreg(ADDR_INTERRUPT_CONTROL, 8'h00);
        pins <= 3'h2;
        rreg(ADDR_INTERRUPT_CONTROL, 8'h01);
        wreg(ADDR_INTERRUPT_CONTROL, 8'h89);
        check_out(13'(irq), 13'h1);
        wreg(ADDR_INTERRUPT_CONTROL, 8'h00);
        // Flags cleared first, then enables set: no interrupt appears.
        wreg(ADDR_INTERRUPT_CONTROL, 8'hb8);
        check_out(13'(irq), 13'h0);
        wreg(ADDR_INTERRUPT_CONTROL, 8'h00);
        // Conversion flag needs its enable, the peripheral and global gates.
        pulse(1);
        rreg(ADDR_PERIPH_IRQ_FLAGS, 8'h40);
        wreg(ADDR_PERIPH_IRQ_ENABLES, 8'hff);
        rreg(ADDR_PERIPH_IRQ_ENABLES, 8'h40);
        wreg(ADDR_INTERRUPT_CONTROL, 8'h80);
        check_out(13'(irq), 13'h0);
        wreg(ADDR_INTERRUPT_CONTROL, 8'hc0);
        check_out(13'(irq), 13'h1);
        wreg(ADDR_PERIPH_IRQ_FLAGS, 8'h00);
        check_out(13'(irq), 13'h0);
        // Status bit set by software; trim precedence and empty bits.
        wreg(ADDR_POWER_RESET_STATUS, 8'hff);
        rreg(ADDR_POWER_RESET_STATUS, 8'h02);
        wreg(ADDR_OSCILLATOR_TRIM, 8'hff);
        rreg(ADDR_OSCILLATOR_TRIM, 8'hfc);
        check_out({7'h00, tfine, tstep}, 13'h3d);
        wreg(ADDR_OSCILLATOR_TRIM, 8'h54);
        check_out({7'h00, tfine, tstep}, 13'h16);
        // Counter loads: low byte write, jump, step and vector.
        wreg(ADDR_PC_HIGH_LATCH, 8'h1f);
        wreg(ADDR_PC_LOW_BYTE, 8'h34);
        check_out(pc, 13'h1f34);
        rreg(ADDR_PC_LOW_BYTE, 8'h34);
        jtgt <= 11'h5aa;
        pulse(3);
        check_out(pc, {2'b11, 11'h5aa});
        pulse(2);
        check_out(pc, {2'b11, 11'h5ab});
        pulse(4);
        check_out(pc, 13'h0004);
        // Nine pushes overwrite the first entry; pops run round the ring.
        wreg(ADDR_PC_HIGH_LATCH, 8'h00);
        for (int i = 0; i < 9; i++) begin
            wreg(ADDR_PC_LOW_BYTE, 8'(i * 3 + 1));
            stk(STK_PUSH);
        end
        wreg(ADDR_PC_HIGH_LATCH, 8'h15);
        for (int i = 8; i >= 0; i--) begin
            stk(STK_POP);
            check_out(pc, 13'((i == 0 ? 8 : i) * 3 + 1));
        end
        wreg(ADDR_PC_LOW_BYTE, 8'h77);
        check_out(pc, 13'h1577);
        // Push and pop back to back return the pushed counter.
        @(posedge clk);
        sop <= STK_PUSH;
        @(posedge clk);
        sop <= STK_POP;
        @(posedge clk);
        sop <= STK_NONE;
        @(negedge clk);
        check_out(pc, 13'h1577);
        // A later reset clears the counter but keeps the status bit.
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (16) @(posedge clk);
        check_out(pc, 13'h0000);
        rst_n <= 1'b1;
        rreg(ADDR_POWER_RESET_STATUS, 8'h02);
        rreg(ADDR_TIMER_PRESCALE_OPT, RST_OPTIONS);
        repeat (3) @(posedge clk);
        give_verdict();
    end
endmodule
